// file: rtl/pec_cfg.svh
`ifndef PEC_CFG_SVH
`define PEC_CFG_SVH
// register word offsets (byte addresses on the bus)
`define PEC_OFS_PA_RISE   8'h00
`define PEC_OFS_PA_FALL   8'h04
`define PEC_OFS_PA_FLAG   8'h08
`define PEC_OFS_PB_RISE   8'h0c
`define PEC_OFS_PB_FALL   8'h10
`define PEC_OFS_PB_FLAG   8'h14
`define PEC_OFS_INT_CTRL  8'h18
`define PEC_OFS_IRQ_STAT  8'h1c
`define PEC_OFS_IRQ_MASK  8'h20
// implemented bit masks
`define PEC_PA_MASK       8'h3b
`define PEC_PB_MASK       8'hf0
// interrupt control layout
`define PEC_IC_ENABLE_BIT 3
`define PEC_IC_FLAG_BIT   0
`define PEC_IC_MASK       8'h08
// sticky status layout
`define PEC_ST_EDGE_BIT   0
`define PEC_ST_WAKE_BIT   1
`define PEC_ST_MASK       8'h03
// reset value of every register
`define PEC_RST_BYTE      8'h00
`endif

// file: rtl/pec_pkg.sv
package pec_pkg;
  // bus slave phase
  typedef enum logic [0:0] {
    PEC_IDLE = 1'b0,
    PEC_ACK  = 1'b1
  } pec_bus_type;
endpackage

// file: rtl/pec_pin_detect.sv
`timescale 1ns/10ps
`include "pec_cfg.svh"
module pec_pin_detect (
  input  wire logic sys_clk,   // system clock
  input  wire logic rst_n,     // sync reset, active low
  input  wire logic pin,       // asynchronous pin level
  input  wire logic rise_en,   // rising edge enable
  input  wire logic fall_en,   // falling edge enable
  output logic      edge_hit   // one-cycle enabled edge pulse
);
  logic meta_q;  // first sync stage, read only by sync_q
  logic sync_q;  // second sync stage
  logic prev_q;  // previous synced sample

  // two-flop synchroniser then history
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      prev_q <= 1'b0;
    end else begin
      meta_q <= pin;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  // compare samples; disabled edges are dropped
  assign edge_hit = (rise_en & sync_q & ~prev_q) |
                    (fall_en & ~sync_q & prev_q);

  // a pin may legally toggle every cycle, so only a stable level is wrong
  chk_one_cycle_pulse: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    edge_hit |=> (!edge_hit || sync_q != prev_q))
    else $error("edge pulse held two cycles");
  chk_rise_ignored: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (!rise_en && sync_q && !prev_q) |-> !edge_hit)
    else $error("rise seen while disabled");
endmodule // pec_pin_detect

// file: rtl/pec_top.sv
`timescale 1ns/10ps
`include "pec_cfg.svh"
// How it works
// - port b rising enables detect rising edges
// - port b falling enables detect falling edges
// - enabled edge sets that pin's flag
// - port b flag also sets summary flag
// - software clears a flag writing zero
// - hardware sets flags independent of writes
// - port b bits three to zero read zero
// - all enables and flags reset zero
// - port a implements bits 5,4,3,1,0 only
// - detection continues while master enable clear
// - summary flag is OR of flags
// - edge during write leaves flag set
// - enabled edge wakes device while master enable set, flags first
module pec_top
  import pec_pkg::*;
(
  input  wire logic       sys_clk,   // system clock, 25 MHz
  input  wire logic       rst_n,     // sync reset, active low
  input  wire logic [7:0] port_a_pin,// port a pin levels
  input  wire logic [7:0] port_b_pin,// port b pin levels
  input  wire logic       cyc_i,     // wishbone cycle
  input  wire logic       stb_i,     // wishbone strobe
  input  wire logic       we_i,      // wishbone write
  input  wire logic [7:0] adr_i,     // wishbone byte address
  input  wire logic [3:0] sel_i,     // wishbone byte selects
  input  wire logic [31:0] dat_i,    // wishbone write data
  output logic [31:0]     dat_o,     // wishbone read data
  output logic            ack_o,     // wishbone acknowledge
  output logic            change_irq,// cpu change interrupt
  output logic            wake_req,  // wake-from-sleep request
  output logic            irq_o      // masked sticky interrupt
);
  logic [7:0]  pa_rise_q;    // porta_rise_enable
  logic [7:0]  pa_fall_q;    // porta_fall_enable
  logic [7:0]  pa_flag_q;    // porta_change_flags
  logic [7:0]  pb_rise_q;    // portb_rise_enable
  logic [7:0]  pb_fall_q;    // portb_fall_enable
  logic [7:0]  pb_flag_q;    // portb_change_flags
  logic        master_en_q;  // change_irq_master_enable
  logic [7:0]  stat_q;       // sticky event status
  logic [7:0]  mask_q;       // status mask
  logic [7:0]  pa_hit;       // port a enabled edge pulses
  logic [7:0]  pb_hit;       // port b enabled edge pulses
  logic        summary;      // change_irq_summary_flag
  logic        any_hit;      // any enabled edge this cycle
  pec_bus_type bus_q;        // bus slave phase
  logic        take;         // request taken this edge
  logic        wr;           // write taken this edge
  logic [7:0]  wbyte;        // low byte of write data
  logic [7:0]  rd_d;         // read mux result

  // one detector per pin; unimplemented pins get zero enables
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_pin
      pec_pin_detect u_a (
        .sys_clk  (sys_clk),
        .rst_n    (rst_n),
        .pin      (port_a_pin[gi]),
        .rise_en  (pa_rise_q[gi]),
        .fall_en  (pa_fall_q[gi]),
        .edge_hit (pa_hit[gi])
      );
      pec_pin_detect u_b (
        .sys_clk  (sys_clk),
        .rst_n    (rst_n),
        .pin      (port_b_pin[gi]),
        .rise_en  (pb_rise_q[gi]),
        .fall_en  (pb_fall_q[gi]),
        .edge_hit (pb_hit[gi])
      );
    end
  endgenerate

  // summary is pure OR, so it clears with the last flag
  assign summary = |pa_flag_q | |pb_flag_q;
  assign any_hit = |pa_hit | |pb_hit;

  // single-wait slave: ack one cycle after strobe, then drop
  // read data is latched at the taking edge so it stands with ack
  assign take  = cyc_i & stb_i & (bus_q == PEC_IDLE);
  // writes land on the ack edge, where the master still holds its
  // request; landing earlier would act before the handshake completes
  assign wr    = cyc_i & stb_i & ack_o & we_i & sel_i[0];
  assign wbyte = dat_i[7:0];

  // bus phase
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      bus_q <= PEC_IDLE;
      ack_o <= 1'b0;
    end else begin
      unique case (bus_q)
        PEC_IDLE: begin
          bus_q <= take ? PEC_ACK : PEC_IDLE;
          ack_o <= take;
        end
        PEC_ACK: begin
          bus_q <= PEC_IDLE;
          ack_o <= 1'b0;
        end
      endcase
    end
  end

  // enable registers; unimplemented bits never store
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      pa_rise_q   <= `PEC_RST_BYTE;
      pa_fall_q   <= `PEC_RST_BYTE;
      pb_rise_q   <= `PEC_RST_BYTE;
      pb_fall_q   <= `PEC_RST_BYTE;
      master_en_q <= 1'b0;
      mask_q      <= `PEC_RST_BYTE;
    end else if (wr) begin
      unique case (adr_i)
        `PEC_OFS_PA_RISE: pa_rise_q <= wbyte & `PEC_PA_MASK;
        `PEC_OFS_PA_FALL: pa_fall_q <= wbyte & `PEC_PA_MASK;
        `PEC_OFS_PB_RISE: pb_rise_q <= wbyte & `PEC_PB_MASK;
        `PEC_OFS_PB_FALL: pb_fall_q <= wbyte & `PEC_PB_MASK;
        `PEC_OFS_INT_CTRL:
          master_en_q <= wbyte[`PEC_IC_ENABLE_BIT];
        `PEC_OFS_IRQ_MASK: mask_q <= wbyte & `PEC_ST_MASK;
        default: ;  // other offsets hold
      endcase
    end
  end

  // port a flags: write replaces, but an edge always wins
  // a zero written in the edge's cycle must not swallow that edge
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      pa_flag_q <= `PEC_RST_BYTE;
    end else if (wr && adr_i == `PEC_OFS_PA_FLAG) begin
      pa_flag_q <= (wbyte & `PEC_PA_MASK) | pa_hit;
    end else begin
      pa_flag_q <= pa_flag_q | pa_hit;
    end
  end

  // port b flags, same policy
  // low nibble is masked on write, so it can never hold a one
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      pb_flag_q <= `PEC_RST_BYTE;
    end else if (wr && adr_i == `PEC_OFS_PB_FLAG) begin
      pb_flag_q <= (wbyte & `PEC_PB_MASK) | pb_hit;
    end else begin
      pb_flag_q <= pb_flag_q | pb_hit;
    end
  end

  // sticky status: write one clears, a new event wins
  // bit 1 only records edges seen while the master enable is set
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      stat_q <= `PEC_RST_BYTE;
    end else begin
      stat_q[`PEC_ST_EDGE_BIT] <= any_hit |
        (stat_q[`PEC_ST_EDGE_BIT] &
         ~(wr && adr_i == `PEC_OFS_IRQ_STAT && wbyte[`PEC_ST_EDGE_BIT]));
      stat_q[`PEC_ST_WAKE_BIT] <= (any_hit & master_en_q) |
        (stat_q[`PEC_ST_WAKE_BIT] &
         ~(wr && adr_i == `PEC_OFS_IRQ_STAT && wbyte[`PEC_ST_WAKE_BIT]));
      stat_q[7:2] <= 6'h00;
    end
  end

  // outputs come from flops; change_irq and wake_req gate on master enable, irq_o on mask_q
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      change_irq <= 1'b0;
      wake_req   <= 1'b0;
      irq_o      <= 1'b0;
    end else begin
      change_irq <= master_en_q & summary;
      // wake follows the flags, so they are set before any wake
      wake_req   <= master_en_q & summary;
      irq_o      <= |(stat_q & mask_q);
    end
  end

  // read mux; unmapped and reserved bits read zero
  always_comb begin
    rd_d = `PEC_RST_BYTE;
    unique case (adr_i)
      `PEC_OFS_PA_RISE:  rd_d = pa_rise_q;
      `PEC_OFS_PA_FALL:  rd_d = pa_fall_q;
      `PEC_OFS_PA_FLAG:  rd_d = pa_flag_q;
      `PEC_OFS_PB_RISE:  rd_d = pb_rise_q;
      `PEC_OFS_PB_FALL:  rd_d = pb_fall_q;
      `PEC_OFS_PB_FLAG:  rd_d = pb_flag_q;
      `PEC_OFS_INT_CTRL: begin
        rd_d[`PEC_IC_ENABLE_BIT] = master_en_q;
        rd_d[`PEC_IC_FLAG_BIT]   = summary;
      end
      `PEC_OFS_IRQ_STAT: rd_d = stat_q;
      `PEC_OFS_IRQ_MASK: rd_d = mask_q;
      default:           rd_d = `PEC_RST_BYTE;
    endcase
  end

  // read data registered with the ack
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      dat_o <= 32'h0000_0000;
    end else if (take) begin
      dat_o <= {24'h00_0000, rd_d};
    end
  end

  // checks
  chk_flag_set_edge: assert property (@(posedge sys_clk) disable iff (!rst_n)
    pb_hit[4] |=> pb_flag_q[4]) else $error("port b flag missed edge");
  chk_edge_beats_clr: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    (wr && adr_i == `PEC_OFS_PB_FLAG && |pb_hit)
    |=> ((pb_flag_q & $past(pb_hit)) == $past(pb_hit)))
    else $error("port b clear beat edge");
  chk_clear_by_zero: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (wr && adr_i == `PEC_OFS_PB_FLAG && !wbyte[5] && !pb_hit[5])
    |=> !pb_flag_q[5]) else $error("flag not cleared");
  chk_pb_low_zero: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (pb_rise_q[3:0] == 4'h0) && (pb_flag_q[3:0] == 4'h0))
    else $error("port b low nibble set");
  chk_pa_hole_zero: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (pa_flag_q[7:6] == 2'h0) && !pa_flag_q[2] && !pa_fall_q[2])
    else $error("port a hole set");
  chk_irq_follows: assert property (@(posedge sys_clk) disable iff (!rst_n)
    ##1 change_irq == $past(master_en_q && summary))
    else $error("irq wrong");
  chk_detect_no_en: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (!master_en_q && pa_hit[1]) |=> (pa_flag_q[1] && !change_irq))
    else $error("detection stopped or irq leaked");
  chk_reset_zero: assert property (@(posedge sys_clk)
    !rst_n |=> (pb_flag_q == 8'h00 && pa_rise_q == 8'h00 && !master_en_q))
    else $error("reset value wrong");
  chk_ack_one: assert property (@(posedge sys_clk) disable iff (!rst_n)
    ack_o |=> !ack_o) else $error("ack held");
  cov_pb_edge: cover property (@(posedge sys_clk) disable iff (!rst_n)
    pb_hit[7] ##1 change_irq);
  cov_race: cover property (@(posedge sys_clk) disable iff (!rst_n)
    pb_hit[7] && wr && adr_i == `PEC_OFS_PB_FLAG);
  cov_irq: cover property (@(posedge sys_clk) disable iff (!rst_n) irq_o);

  // an edge seen with the master enable set reaches the wake request
  cov_wake: cover property (@(posedge sys_clk) disable iff (!rst_n)
    (any_hit && master_en_q) ##2 wake_req);

  // detection without the master enable, irq held back
  cov_quiet_detect: cover property (@(posedge sys_clk) disable iff (!rst_n)
    any_hit && !master_en_q);

  // port a side of the clear race; software may clear while pins move
  chk_pa_beats_clr: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    (wr && adr_i == `PEC_OFS_PA_FLAG && |pa_hit)
    |=> ((pa_flag_q & $past(pa_hit)) == $past(pa_hit)))
    else $error("port a clear beat edge");

  // wake request is the registered copy of enable and summary
  chk_wake_follows: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    ##1 wake_req == $past(master_en_q && summary))
    else $error("wake request wrong");

  // status interrupt is the registered masked status
  chk_irq_o_follows: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    ##1 irq_o == $past(|(stat_q & mask_q)))
    else $error("status irq wrong");

  // any enabled edge lands in the sticky status
  chk_status_set: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    any_hit |=> stat_q[`PEC_ST_EDGE_BIT])
    else $error("status missed edge");

  // a set status bit only leaves through a write-one clear
  chk_status_sticky: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    (stat_q[`PEC_ST_EDGE_BIT] && !(wr && adr_i == `PEC_OFS_IRQ_STAT
      && wbyte[`PEC_ST_EDGE_BIT])) |=> stat_q[`PEC_ST_EDGE_BIT])
    else $error("status dropped");

  // every taken request is answered on the next edge
  chk_ack_after_take: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    take |=> ack_o)
    else $error("ack missing");

  // a flag stays set unless software writes that register
  chk_flag_hold: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    (pb_flag_q[6] && !(wr && adr_i == `PEC_OFS_PB_FLAG))
    |=> pb_flag_q[6])
    else $error("flag lost without write");
endmodule // pec_top

// file: testbench/pec_pin_src.sv
`timescale 1ns/10ps
// far side: plain digital levels on the port pins
module pec_pin_src (
  input  wire logic       sys_clk, // system clock
  output logic      [7:0] pa,      // port a pin levels
  output logic      [7:0] pb       // port b pin levels
);
  // pins start low, as after a quiet power-up
  initial begin
    pa = 8'h00;
    pb = 8'h00;
  end
  // levels move just after an edge and then hold
  task automatic drive(input logic [7:0] a, input logic [7:0] b);
    @(posedge sys_clk);
    pa <= a;
    pb <= b;
  endtask
endmodule // pec_pin_src

// file: testbench/test_pec_top.sv
`timescale 1ns/10ps
module test_pec_top;
  import pec_pkg::*;
  logic        sys_clk, rst_n, cyc_i, stb_i, we_i; // clock, reset, bus
  logic [7:0]  adr_i, pa, pb;                      // address, pins
  logic [3:0]  sel_i;                              // byte selects
  logic [31:0] dat_i, dat_o, rdat;                 // bus data
  logic        ack_o, change_irq, wake_req, irq_o; // design outputs
  logic [7:0]  ra, fa, rb, fb, na, nb, oa, ob;     // enables, levels
  logic [7:0]  ea, eb, fla, flb, st;               // model state
  logic [1:0]  mk;                                 // model mask
  logic        ie;                                 // model master enable
  int          miscompares, n_checks;              // tallies
  // bus map and implemented bits after writing ff
  logic [7:0] ofs [10] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14,
                           8'h18, 8'h1c, 8'h20, 8'h40};
  logic [7:0] msk [10] = '{8'h3b, 8'h3b, 8'h3b, 8'hf0, 8'hf0, 8'hf0,
                           8'h09, 8'h00, 8'h03, 8'h00};

  pec_top dut (.sys_clk(sys_clk), .rst_n(rst_n), .port_a_pin(pa),
    .port_b_pin(pb), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
    .ack_o(ack_o), .change_irq(change_irq), .wake_req(wake_req),
    .irq_o(irq_o));
  pec_pin_src src (.sys_clk(sys_clk), .pa(pa), .pb(pb));

  // 25 mhz clock
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one classic cycle; the answer is taken only at the ack edge
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    @(posedge sys_clk);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= {24'h0, d};
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (ack_o !== 1'b1 && n < 50);
    if (n >= 50) begin
      miscompares++;
      test_done();
    end
    rdat = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
  endtask
  task automatic zero_check;
    for (int k = 0; k < 10; k++) begin
      wb(1'b0, ofs[k], 8'h00);
      chk(rdat, 32'h0);
    end
    chk(change_irq, 1'b0);
  endtask
  task automatic test_done;
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // cut a hang short
  initial begin
    repeat (20000) @(posedge sys_clk);
    miscompares++;
    test_done();
  end

  initial begin
    {rst_n, cyc_i, stb_i, we_i, adr_i, dat_i} = '0;
    sel_i = 4'h1;
    {oa, ob, fla, flb, st} = '0;
    void'($urandom(32'hd15a902f));
    repeat (10) @(posedge sys_clk);
    rst_n <= 1'b1;
    zero_check();
    // only implemented bits keep a written one
    for (int k = 0; k < 10; k++) begin
      wb(1'b1, ofs[k], 8'hff);
      wb(1'b0, ofs[k], 8'h00);
      chk(rdat, {24'h0, msk[k]});
    end
    chk(change_irq, 1'b1);
    for (int k = 0; k < 9; k++) wb(1'b1, ofs[k], 8'h00);
    $display("test masks done");
    // random enables, levels and master enable against the model
    for (int it = 0; it < 40; it++) begin
      {ra, fa, rb, fb, na, nb} = 48'({$urandom, $urandom});
      {ie, mk} = 3'($urandom);
      foreach (ofs[k]) if (k == 0 || k == 1 || k == 3 || k == 4)
        wb(1'b1, ofs[k], k == 0 ? ra : k == 1 ? fa : k == 3 ? rb : fb);
      wb(1'b1, 8'h18, {4'h0, ie, 3'h0});
      wb(1'b1, 8'h20, {6'h0, mk});
      ea = (ra & na & ~oa | fa & oa & ~na) & 8'h3b;
      eb = (rb & nb & ~ob | fb & ob & ~nb) & 8'hf0;
      fla |= ea;
      flb |= eb;
      if (|{ea, eb}) st |= {6'h0, ie, 1'b1};
      src.drive(na, nb);
      repeat (6) @(posedge sys_clk);
      wb(1'b0, 8'h08, 8'h00);
      chk(rdat, {24'h0, fla});
      wb(1'b0, 8'h14, 8'h00);
      chk(rdat, {24'h0, flb});
      wb(1'b0, 8'h18, 8'h00);
      chk(rdat, {28'h0, ie, 3'h0} | (|{fla, flb}));
      chk(change_irq, ie & |{fla, flb});
      chk(wake_req, ie & |{fla, flb});
      wb(1'b0, 8'h1c, 8'h00);
      chk(rdat, {24'h0, st});
      chk(irq_o, |(st[1:0] & mk));
      if (it[0]) begin
        wb(1'b1, 8'h08, 8'h00);
        wb(1'b1, 8'h14, 8'h00);
        wb(1'b1, 8'h1c, 8'h03);
        {fla, flb, st} = '0;
        repeat (2) @(posedge sys_clk);
        chk(change_irq, 1'b0);
        chk(irq_o, 1'b0);
      end
      {oa, ob} = {na, nb};
    end
    $display("test random done");
    // edge landing on the clearing write still leaves its flag set
    src.drive(8'h00, 8'h00);
    wb(1'b1, 8'h0c, 8'h80);
    wb(1'b1, 8'h14, 8'h00);
    fork
      src.drive(8'h00, 8'h80);
      begin
        repeat (1) @(posedge sys_clk);
        wb(1'b1, 8'h14, 8'h00);
      end
    join
    repeat (4) @(posedge sys_clk);
    wb(1'b0, 8'h14, 8'h00);
    chk(rdat, 32'h80);
    $display("test clear race done");
    // second reset in mid-run
    wb(1'b1, 8'h00, 8'hff);
    rst_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    zero_check();
    $display("test rerun reset done");
    test_done();
  end
endmodule // test_pec_top
